//--- bench/async_serial_port_test.sv
module async_serial_port_test
	import async_serial_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TIMEOUT_CYCLES = 90000;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  bus_addr = 4'h0;
	logic        bus_rd = 1'b0;
	logic        bus_wr = 1'b0;
	logic [31:0] bus_wdata = 32'h0000_0000;
	logic [31:0] bus_rdata;
	logic        bus_wait;
	logic        ext_clk = 1'b0;
	logic        ext_run = 1'b0;
	logic [1:0]  ext_div = 2'h0;
	logic        ext_clk_out;
	logic        ext_clk_oe;
	logic        rxd;
	logic        txd;
	logic        txd_oe;
	logic        txd_line;
	logic        irq;
	logic [15:0] bit_cycles = 16'h0010;
	logic [31:0] q;
	int          err_count = 0;
	int          total_checks = 0;
	int          cycle_count = 0;
	int          zero_cnt = 0;
	int          n;
	int          divs[4] = '{DIV_RATE0, DIV_RATE1, DIV_RATE2, DIV_RATE3};

	always #5 clk = ~clk;

	// Released output line floats high through the pull-up
	assign txd_line = (txd_oe === 1'b1) ? txd : 1'b1;

	async_serial_port i_dut (
		.mclk_in            (clk),
		.reset_in           (rst),
		.avs_address_in     (bus_addr),
		.avs_read_in        (bus_rd),
		.avs_write_in       (bus_wr),
		.avs_writedata_in   (bus_wdata),
		.avs_byteenable_in  (4'hF),
		.avs_readdata_out   (bus_rdata),
		.avs_waitrequest_out(bus_wait),
		.clk_pin_in         (ext_clk),
		.clk_pin_out        (ext_clk_out),
		.clk_pin_oe_out     (ext_clk_oe),
		.rxd_in             (rxd),
		.txd_out            (txd),
		.txd_oe_out         (txd_oe),
		.irq_out            (irq)
	);

	serial_remote_model i_remote (
		.clk_in       (clk),
		.line_in      (txd_line),
		.bit_cycles_in(bit_cycles),
		.line_out     (rxd)
	);

	// External bit clock at a quarter of the system clock
	always @(posedge clk) begin
		ext_div <= ext_div + 2'h1;
		if (ext_run) ext_clk <= ext_div[1];
	end

	always @(posedge clk) begin
		if (txd_oe === 1'b1 && txd === 1'b0) zero_cnt <= zero_cnt + 1;
		cycle_count <= cycle_count + 1;
		if (cycle_count == TIMEOUT_CYCLES) begin
			err_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic bus_access(input logic [3:0] a, input logic w, input logic [7:0] d, output logic [31:0] r);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= {24'h00_0000, d};
		bus_rd <= ~w;
		bus_wr <= w;
		@(posedge clk);
		while (bus_wait !== 1'b0) @(posedge clk);
		r = bus_rdata;
		bus_rd <= 1'b0;
		bus_wr <= 1'b0;
	endtask : bus_access

	task automatic reg_check(input logic [3:0] a, input logic [7:0] exp);
		logic [31:0] r;
		bus_access(a, 1'b0, 8'h00, r);
		check(r, {24'h00_0000, exp});
	endtask : reg_check

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus_access(a, 1'b1, d, r);
		@(negedge clk);
	endtask : reg_write

	// Status read with empty seen, then holding write
	task automatic send_tx(input logic [7:0] d);
		logic [31:0] r;
		r = 32'h0000_0000;
		while (r[BIT_TX_EMPTY] !== 1'b1) bus_access(OFF_CTRL_STATUS, 1'b0, 8'h00, r);
		reg_write(OFF_TX_HOLDING, d);
	endtask : send_tx

	task automatic remote_send(input logic [7:0] d, input logic stop);
		i_remote.send_frame(d, stop);
		repeat (8) @(posedge clk);
	endtask : remote_send

	task automatic clk_period(output int p);
		p = 0;
		for (int k = 0; k < 3; k++) begin
			p = 0;
			while (ext_clk_out !== 1'b0) begin
				@(negedge clk);
				p++;
			end
			while (ext_clk_out !== 1'b1) begin
				@(negedge clk);
				p++;
			end
		end
	endtask : clk_period

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		reg_check(OFF_CTRL_STATUS, 8'h20);
		reg_check(OFF_RATE_MODE, 8'h00);
		check(32'(irq), 32'h0);
		check(32'(txd_oe), 32'h0);
		for (int r = 0; r < 4; r++) begin
			reg_write(OFF_RATE_MODE, {4'h0, FMT_INT_OUT, 2'(r)});
			check(32'(ext_clk_oe), 32'h1);
			clk_period(n);
			check(32'(n), 32'(divs[r]));
		end
		reg_write(OFF_RATE_MODE, {4'h0, FMT_INT, 2'b00});
		check(32'(ext_clk_oe), 32'h0);
		reg_write(OFF_CTRL_STATUS, 8'h06);
		check(32'(txd_oe), 32'h1);
		repeat (2) @(posedge clk);
		check(32'(irq), 32'h1);
		repeat (320) @(posedge clk);
		check(32'(zero_cnt), 32'h0);
		reg_check(OFF_CTRL_STATUS, 8'h26);
		send_tx(8'hA5);
		send_tx(8'h3C);
		while (i_remote.got_q.size() < 2) @(posedge clk);
		check(32'(i_remote.got_q[0]), 32'h0000_00A5);
		check(32'(i_remote.got_q[1]), 32'h0000_003C);
		repeat (100) @(posedge clk);
		check(32'(i_remote.got_q.size()), 32'h2);
		reg_write(OFF_CTRL_STATUS, 8'h1A);
		remote_send(8'h5A, 1'b1);
		check(32'(irq), 32'h1);
		reg_check(OFF_CTRL_STATUS, 8'hBA);
		reg_check(OFF_RX_HOLDING, 8'h5A);
		reg_check(OFF_CTRL_STATUS, 8'h3A);
		check(32'(irq), 32'h0);
		remote_send(8'h11, 1'b0);
		reg_check(OFF_CTRL_STATUS, 8'h7A);
		reg_check(OFF_RX_HOLDING, 8'h5A);
		reg_check(OFF_CTRL_STATUS, 8'h3A);
		remote_send(8'h21, 1'b1);
		remote_send(8'h42, 1'b1);
		reg_check(OFF_CTRL_STATUS, 8'hFA);
		reg_check(OFF_RX_HOLDING, 8'h21);
		reg_check(OFF_CTRL_STATUS, 8'h3A);
		reg_write(OFF_CTRL_STATUS, 8'h02);
		remote_send(8'h77, 1'b1);
		reg_check(OFF_CTRL_STATUS, 8'h22);
		bit_cycles = 16'h0020;
		ext_run <= 1'b1;
		reg_write(OFF_RATE_MODE, {4'h0, FMT_EXT, 2'b00});
		check(32'(ext_clk_oe), 32'h0);
		reg_write(OFF_CTRL_STATUS, 8'h00);
		check(32'(txd_oe), 32'h0);
		check(32'(txd), 32'h1);
		repeat (64) @(posedge clk);
		reg_write(OFF_CTRL_STATUS, 8'h0A);
		send_tx(8'h96);
		while (i_remote.got_q.size() < 3) @(posedge clk);
		check(32'(i_remote.got_q[2]), 32'h0000_0096);
		remote_send(8'h69, 1'b1);
		reg_check(OFF_CTRL_STATUS, 8'hAA);
		reg_check(OFF_RX_HOLDING, 8'h69);
		check(32'(i_remote.bad_stop), 32'h0);
		report_and_stop();
	end

endmodule : async_serial_port_test

//--- bench/serial_remote_model.sv
module serial_remote_model (
	input  wire logic        clk_in,
	input  wire logic        line_in,
	input  wire logic [15:0] bit_cycles_in,
	output logic             line_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] got_q[$];
	logic [7:0] shift;
	int         bad_stop;

	initial begin
		line_out = 1'b1;
		bad_stop = 0;
	end

	// Idle mark between frames; stop may be forced low on request
	task automatic send_frame(input logic [7:0] data, input logic stop);
		logic [9:0] frame;
		frame = {stop, data, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_out <= frame[i];
			repeat (bit_cycles_in) @(posedge clk_in);
		end
		line_out <= 1'b1;
	endtask : send_frame

	// Decode the device output at bit centres
	always begin
		@(posedge clk_in);
		if (line_in === 1'b0) begin
			repeat (bit_cycles_in / 16'd2) @(posedge clk_in);
			for (int i = 0; i < 8; i++) begin
				repeat (bit_cycles_in) @(posedge clk_in);
				shift[i] = line_in;
			end
			repeat (bit_cycles_in) @(posedge clk_in);
			if (line_in !== 1'b1) bad_stop++;
			got_q.push_back(shift);
		end
	end

endmodule : serial_remote_model

//--- verilog/async_serial_pkg.sv
package async_serial_pkg;

	// Avalon byte offsets, one word each
	localparam logic [3:0] OFF_CTRL_STATUS = 4'h0;
	localparam logic [3:0] OFF_RATE_MODE   = 4'h4;
	localparam logic [3:0] OFF_RX_HOLDING  = 4'h8;
	localparam logic [3:0] OFF_TX_HOLDING  = 4'hC;

	// Control/status field positions
	localparam int BIT_RX_FULL   = 7;
	localparam int BIT_ERROR     = 6;
	localparam int BIT_TX_EMPTY  = 5;
	localparam int BIT_RX_IRQ_EN = 4;
	localparam int BIT_RX_EN     = 3;
	localparam int BIT_TX_IRQ_EN = 2;
	localparam int BIT_TX_EN     = 1;
	localparam int BIT_WAKE      = 0;
	localparam int CTRL_WIDTH    = 5;

	localparam logic [7:0] CTRL_STATUS_RESET = 8'h20;
	localparam logic [3:0] RATE_MODE_RESET   = 4'h0;

	// Clock/format codes
	localparam logic [1:0] FMT_NONE     = 2'h0;
	localparam logic [1:0] FMT_INT      = 2'h1;
	localparam logic [1:0] FMT_INT_OUT  = 2'h2;
	localparam logic [1:0] FMT_EXT      = 2'h3;

	// System clocks per bit for rate codes 00..11
	localparam int DIV_RATE0 = 16;
	localparam int DIV_RATE1 = 128;
	localparam int DIV_RATE2 = 1024;
	localparam int DIV_RATE3 = 4096;
	localparam int TICKS_PER_BIT = 8;
	localparam int DIV_WIDTH     = 9;

	localparam logic [3:0] PREAMBLE_BITS = 4'hA;
	localparam logic [3:0] FRAME_BITS    = 4'hA;
	localparam logic [2:0] SAMPLE_TICK   = 3'h3;
	localparam logic [2:0] LAST_TICK     = 3'h7;

	typedef enum logic [3:0] {
		TX_OFF  = 4'b0001,
		TX_PRE  = 4'b0010,
		TX_IDLE = 4'b0100,
		TX_DATA = 4'b1000
	} tx_state_type;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b01,
		RX_BUSY = 2'b10
	} rx_state_type;

	typedef struct packed {
		logic rx_full;
		logic error;
		logic tx_empty;
	} flags_type;

endpackage : async_serial_pkg

//--- verilog/async_serial_port.sv
// Operation
// - Clock/format codes 01 internal, 10 internal driven out, 11 external; all NRZ.
// - Code 10 drives bit clock on clock pin regardless of enables.
// - Serial input used only with receive enabled, output only with transmit enabled.
// - Rate/mode register is 4-bit, write-only, cleared at reset.
// - Rate codes divide system clock by 16, 128, 1024, 4096.
// - Driven-out clock runs at bit rate, at most system clock over 16.
// - External clock divided by 8 forms bit rate; source at most half system clock.
// - Transmit enable forces transmit pin as output carrying shift register.
// - Setting transmit enable sends ten mark bits first.
// - Ready transmitter sends marks when empty, else loads data and starts frame.
// - Frame is start 0, eight data bits LSB first, stop 1.
// - Transmit-empty set on load and reset; cleared by status read then holding write.
// - No start bit sent while transmit-empty stays set.
// - Receiver syncs on first 0 and samples ten bits near centre.
// - Stop bit 0 sets error flag, receive-full unchanged.
// - Stop bit 1 with receive-full clear copies byte to holding register, sets receive-full.
// - Frame end while receive-full set flags overrun error.
// - Status read then holding read clears receive-full and error; reset too.
// - Receiver tolerates 37.5 percent bit and +3.75/-2.5 percent character error.
// - Receive-full, error and transmit-empty combine into one interrupt request.
// - Request only when enabled flag conditions hold.
module async_serial_port
	import async_serial_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        reset_in,
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        clk_pin_in,
	output logic             clk_pin_out,
	output logic             clk_pin_oe_out,
	input  wire logic        rxd_in,
	output logic             txd_out,
	output logic             txd_oe_out,
	output logic             irq_out
);

	function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
		hit = (addr[3:2] == off[3:2]);
	endfunction : hit

	function automatic logic [DIV_WIDTH-1:0] tick_limit(input logic [1:0] rate);
		case (rate)
			2'h0:    tick_limit = DIV_WIDTH'(DIV_RATE0 / TICKS_PER_BIT - 1);
			2'h1:    tick_limit = DIV_WIDTH'(DIV_RATE1 / TICKS_PER_BIT - 1);
			2'h2:    tick_limit = DIV_WIDTH'(DIV_RATE2 / TICKS_PER_BIT - 1);
			default: tick_limit = DIV_WIDTH'(DIV_RATE3 / TICKS_PER_BIT - 1);
		endcase
	endfunction : tick_limit

	logic                  ack_q;
	logic [31:0]           readdata_q;
	logic [3:0]            rate_mode_q;
	logic [CTRL_WIDTH-1:0] ctrl_q;
	flags_type             flags_q;
	logic                  tx_arm_q;
	logic                  rx_arm_q;
	logic [7:0]            tx_holding_q;
	logic [7:0]            rx_holding_q;
	logic                  clk_s1_q;
	logic                  clk_s2_q;
	logic                  clk_s3_q;
	logic                  rxd_s1_q;
	logic                  rxd_s2_q;
	logic [DIV_WIDTH-1:0]  div_cnt_q;
	logic [2:0]            phase_q;
	tx_state_type          tx_state_q;
	logic [3:0]            tx_cnt_q;
	logic [9:0]            tx_shift_q;
	rx_state_type          rx_state_q;
	logic [2:0]            rx_sub_q;
	logic [3:0]            rx_bit_q;
	logic [7:0]            rx_shift_q;
	logic                  irq_q;

	logic                  bus_req;
	logic                  bus_take;
	logic                  wr_ctrl;
	logic                  wr_rate;
	logic                  wr_tx_hold;
	logic                  rd_ctrl;
	logic                  rd_rx_hold;
	logic [1:0]            fmt;
	logic                  int_clock;
	logic                  clk_rise;
	logic                  tick;
	logic                  bit_tick;
	logic                  tx_en;
	logic                  rx_en;
	logic                  tx_slot;
	logic                  tx_load;
	logic                  rx_sample;
	logic                  rx_done;
	logic                  rx_store;
	logic                  rx_error;
	logic                  rx_clear;

	// Bus slave: one wait cycle, then the access completes
	assign bus_req             = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = bus_req & ~ack_q;
	assign bus_take            = bus_req & ack_q;
	assign avs_readdata_out    = readdata_q;
	assign wr_ctrl    = bus_take & avs_write_in & avs_byteenable_in[0] & hit(avs_address_in, OFF_CTRL_STATUS);
	assign wr_rate    = bus_take & avs_write_in & avs_byteenable_in[0] & hit(avs_address_in, OFF_RATE_MODE);
	assign wr_tx_hold = bus_take & avs_write_in & avs_byteenable_in[0] & hit(avs_address_in, OFF_TX_HOLDING);
	assign rd_ctrl    = bus_take & avs_read_in & hit(avs_address_in, OFF_CTRL_STATUS);
	assign rd_rx_hold = bus_take & avs_read_in & hit(avs_address_in, OFF_RX_HOLDING);

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= bus_req & ~ack_q;
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			readdata_q <= 32'h0000_0000;
		end else if (avs_read_in & ~ack_q) begin
			if (hit(avs_address_in, OFF_CTRL_STATUS)) begin
				readdata_q <= {24'h00_0000, flags_q, ctrl_q};
			end else if (hit(avs_address_in, OFF_RX_HOLDING)) begin
				readdata_q <= {24'h00_0000, rx_holding_q};
			end else begin
				readdata_q <= 32'h0000_0000; // Write-only registers read zero
			end
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			rate_mode_q <= RATE_MODE_RESET;
		end else if (wr_rate) begin
			rate_mode_q <= avs_writedata_in[3:0];
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			ctrl_q <= CTRL_STATUS_RESET[CTRL_WIDTH-1:0];
		end else if (wr_ctrl) begin
			ctrl_q <= avs_writedata_in[CTRL_WIDTH-1:0];
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			tx_holding_q <= 8'h00;
		end else if (wr_tx_hold) begin
			tx_holding_q <= avs_writedata_in[7:0];
		end
	end

	assign tx_en = ctrl_q[BIT_TX_EN];
	assign rx_en = ctrl_q[BIT_RX_EN];

	// Pin synchronisers
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_s3_q <= 1'b0;
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
		end else begin
			clk_s1_q <= clk_pin_in;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
			rxd_s1_q <= rxd_in;
			rxd_s2_q <= rxd_s1_q;
		end
	end

	// Eight ticks per bit from either clock source
	assign fmt       = rate_mode_q[3:2];
	assign int_clock = (fmt == FMT_INT) | (fmt == FMT_INT_OUT);
	assign clk_rise  = clk_s2_q & ~clk_s3_q;
	assign tick      = int_clock ? (div_cnt_q == tick_limit(rate_mode_q[1:0]))
	                             : ((fmt == FMT_EXT) & clk_rise);
	assign bit_tick  = tick & (phase_q == LAST_TICK);

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			div_cnt_q <= '0;
		end else if (~int_clock | tick) begin
			div_cnt_q <= '0;
		end else begin
			div_cnt_q <= div_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			phase_q <= 3'h0;
		end else if (tick) begin
			phase_q <= phase_q + 1'b1;
		end
	end

	// Bit clock out: half high, half low per bit
	assign clk_pin_out    = phase_q[2];
	assign clk_pin_oe_out = (fmt == FMT_INT_OUT);

	// Transmitter
	assign tx_slot = bit_tick & ((tx_state_q == TX_IDLE) |
	                 ((tx_state_q == TX_DATA) & (tx_cnt_q == FRAME_BITS - 1'b1)));
	assign tx_load = tx_en & tx_slot & ~flags_q.tx_empty;
	assign txd_out    = tx_shift_q[0];
	assign txd_oe_out = tx_en;

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			tx_state_q <= TX_OFF;
			tx_cnt_q   <= 4'h0;
			tx_shift_q <= 10'h3FF;
		end else if (~tx_en) begin
			tx_state_q <= TX_OFF;
			tx_cnt_q   <= 4'h0;
			tx_shift_q <= 10'h3FF;
		end else begin
			case (tx_state_q)
				TX_OFF: begin
					tx_state_q <= TX_PRE;
					tx_cnt_q   <= 4'h0;
				end
				TX_PRE: begin
					if (bit_tick) begin
						tx_cnt_q <= tx_cnt_q + 1'b1;
						if (tx_cnt_q == PREAMBLE_BITS - 1'b1) begin
							tx_state_q <= TX_IDLE;
						end
					end
				end
				TX_IDLE, TX_DATA: begin
					if (tx_load) begin
						tx_state_q <= TX_DATA;
						tx_cnt_q   <= 4'h0;
						tx_shift_q <= {1'b1, tx_holding_q, 1'b0};
					end else if (tx_slot) begin
						tx_state_q <= TX_IDLE;
						tx_shift_q <= 10'h3FF;
					end else if (bit_tick) begin
						tx_cnt_q   <= tx_cnt_q + 1'b1;
						tx_shift_q <= {1'b1, tx_shift_q[9:1]};
					end
				end
				default: begin
					tx_state_q <= TX_OFF;
				end
			endcase
		end
	end

	// Receiver
	assign rx_sample = rx_en & (rx_state_q == RX_BUSY) & tick & (rx_sub_q == SAMPLE_TICK);
	assign rx_done   = rx_sample & (rx_bit_q == FRAME_BITS - 1'b1);
	assign rx_store  = rx_done & rxd_s2_q & ~flags_q.rx_full;
	assign rx_error  = rx_done & (~rxd_s2_q | flags_q.rx_full);

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			rx_state_q <= RX_IDLE;
			rx_sub_q   <= 3'h0;
			rx_bit_q   <= 4'h0;
			rx_shift_q <= 8'h00;
		end else if (~rx_en) begin
			rx_state_q <= RX_IDLE;
		end else begin
			case (rx_state_q)
				RX_IDLE: begin
					if (tick & ~rxd_s2_q) begin
						rx_state_q <= RX_BUSY;
						rx_sub_q   <= 3'h0;
						rx_bit_q   <= 4'h0;
					end
				end
				RX_BUSY: begin
					if (tick) begin
						rx_sub_q <= rx_sub_q + 1'b1;
					end
					if (rx_sample) begin
						rx_bit_q <= rx_bit_q + 1'b1;
						if ((rx_bit_q == 4'h0) & rxd_s2_q) begin
							rx_state_q <= RX_IDLE; // Start bit gone at centre
						end else if (rx_done) begin
							rx_state_q <= RX_IDLE;
						end else if (rx_bit_q != 4'h0) begin
							rx_shift_q <= {rxd_s2_q, rx_shift_q[7:1]};
						end
					end
				end
				default: begin
					rx_state_q <= RX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			rx_holding_q <= 8'h00;
		end else if (rx_store) begin
			rx_holding_q <= rx_shift_q;
		end
	end

	// Clear sequences: status read arms, data access clears
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			tx_arm_q <= 1'b0;
		end else if (rd_ctrl) begin
			tx_arm_q <= readdata_q[BIT_TX_EMPTY];
		end else if (wr_tx_hold) begin
			tx_arm_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			rx_arm_q <= 1'b0;
		end else if (rd_ctrl) begin
			rx_arm_q <= readdata_q[BIT_RX_FULL] | readdata_q[BIT_ERROR];
		end else if (rd_rx_hold) begin
			rx_arm_q <= 1'b0;
		end
	end

	assign rx_clear = rd_rx_hold & rx_arm_q;

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			flags_q <= CTRL_STATUS_RESET[7:5];
		end else begin
			flags_q.tx_empty <= tx_load | (flags_q.tx_empty & ~(wr_tx_hold & tx_arm_q));
			flags_q.rx_full  <= rx_store | (flags_q.rx_full & ~rx_clear);
			flags_q.error    <= rx_error | (flags_q.error & ~rx_clear);
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (ctrl_q[BIT_RX_IRQ_EN] & (flags_q.rx_full | flags_q.error)) |
			         (ctrl_q[BIT_TX_IRQ_EN] & flags_q.tx_empty);
		end
	end

	assign irq_out = irq_q;

	// Checks
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (reset_in);

	sequence s_load_slot;
		tx_slot & tx_en & ~flags_q.tx_empty;
	endsequence

	sequence s_start_sent;
		(tx_state_q == TX_DATA) & flags_q.tx_empty & ~txd_out;
	endsequence

	a_clock_out_drive: assert property ((fmt == FMT_INT_OUT) & ~tx_en & ~rx_en |-> clk_pin_oe_out)
		else $error("clock pin not driven in clock-out mode");

	a_tx_pin_release: assert property ($fell(tx_en) |-> ~txd_oe_out ##1 txd_out)
		else $error("transmit pin still driven after disable");

	a_rate_write: assert property (wr_rate |=> rate_mode_q == $past(avs_writedata_in[3:0]))
		else $error("rate register did not take written value");

	a_fast_tick: assert property (int_clock & (rate_mode_q[1:0] == 2'h0) & tick & $stable(rate_mode_q) & ~avs_write_in
		|=> ~tick ##1 tick)
		else $error("fastest rate tick spacing wrong");

	a_ext_tick: assert property ((fmt == FMT_EXT) & tick |-> $rose(clk_s2_q))
		else $error("external tick without clock rise");

	a_clock_rate: assert property ($changed(clk_pin_out) |-> $past(tick))
		else $error("bit clock changed without tick");

	a_preamble_marks: assert property (tx_state_q == TX_PRE |-> txd_out)
		else $error("space sent during preamble");

	a_frame_start: assert property (s_load_slot |=> s_start_sent)
		else $error("frame did not start on load");

	a_no_false_start: assert property (flags_q.tx_empty & (tx_state_q == TX_IDLE) |-> txd_out)
		else $error("start bit sent while empty");

	a_framing_error: assert property (rx_done & ~rxd_s2_q |=> flags_q.error & $stable(flags_q.rx_full))
		else $error("framing error not flagged");

	a_rx_store: assert property (rx_done & rxd_s2_q & ~flags_q.rx_full
		|=> flags_q.rx_full & (rx_holding_q == $past(rx_shift_q)))
		else $error("received byte not stored");

	a_overrun: assert property (rx_done & flags_q.rx_full |=> flags_q.error & flags_q.rx_full)
		else $error("overrun not flagged");

	a_rx_clear: assert property (rx_clear & ~rx_done |=> ~flags_q.rx_full & ~flags_q.error)
		else $error("receive flags not cleared");

	a_irq_gate: assert property (##1 irq_out == $past((ctrl_q[BIT_TX_IRQ_EN] & flags_q.tx_empty) |
		(ctrl_q[BIT_RX_IRQ_EN] & (flags_q.rx_full | flags_q.error))))
		else $error("interrupt request mismatch");

	a_bus_answer: assert property (bus_req & avs_waitrequest_out |=> ~avs_waitrequest_out)
		else $error("bus answer late");

endmodule : async_serial_port
